// File: rtl/rtrf_host.sv
// Host controller that frames transmit requests for the radio module.
`include "rtrf_params.svh"
module rtrf_host (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [7:0] tx_byte,
    output logic tx_valid,
    input wire logic tx_ready,
    input wire logic rx_valid,
    input wire logic [7:0] rx_byte
);
    // ------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------
    logic [63:0] dest64_q;
    logic [15:0] dest16_q;
    logic [7:0] frame_id_q;
    logic [7:0] radius_q;
    logic [7:0] opts_q;
    logic [7:0] src_ep_q;
    logic [7:0] dst_ep_q;
    logic [15:0] cluster_q;
    logic [15:0] profile_q;
    logic [7:0] maxpl_q;
    logic [7:0] pl_cnt_q;
    logic explicit_q;
    logic busy_q;
    logic err_q;
    logic resp_q;
    logic [31:0] resp_word_q;
    logic [7:0] pl_mem [`RTRF_PL_DEPTH];
    rtrf_pkg::rtrf_state_t st_q;
    logic [4:0] hidx_q;
    logic [7:0] pidx_q;
    logic [7:0] sum_q;
    logic [7:0] tx_byte_q;
    logic tx_valid_q;

    // APB answers in the access cycle itself: no wait states.
    wire acc = psel && penable;
    wire wr = acc && pwrite;
    wire wr_ctrl = wr && paddr == `RTRF_REG_CTRL;
    wire wr_data = wr && paddr == `RTRF_REG_DATA;
    wire mapped = paddr == `RTRF_REG_CTRL || paddr == `RTRF_REG_STAT ||
        paddr == `RTRF_REG_ADDRH || paddr == `RTRF_REG_ADDRL ||
        paddr == `RTRF_REG_FIELDS || paddr == `RTRF_REG_APP ||
        paddr == `RTRF_REG_MAXPL || paddr == `RTRF_REG_DATA ||
        paddr == `RTRF_REG_RESP;

    // Encrypted options each cost four payload bytes of the maximum.
    wire [7:0] enc_cut =
        ((opts_q & `RTRF_OPT_SECURE) != 8'h00 ? `RTRF_ENC_OVERHEAD : 8'h00) +
        ((opts_q & `RTRF_OPT_LINKKEY) != 8'h00 ? `RTRF_ENC_OVERHEAD : 8'h00);
    wire [7:0] limit = maxpl_q > enc_cut ? maxpl_q - enc_cut : 8'h00;
    // Reserved option bits or too much payload refuse the send.
    wire opt_bad = (opts_q & ~`RTRF_OPT_MASK) != 8'h00;
    wire len_bad = pl_cnt_q > limit;
    wire go = wr_ctrl && pwdata[0] && !busy_q;
    wire go_ok = go && !opt_bad && !len_bad;

    wire [7:0] hdr_len = explicit_q ? `RTRF_HDR_EXPL : `RTRF_HDR_TX;
    wire [15:0] frame_len = {8'h00, hdr_len} + {8'h00, pl_cnt_q};
    wire [4:0] hdr_end = explicit_q ? `RTRF_HDR_EXPL_END : `RTRF_HDR_TX_END;

    // ------------------------------------------------------------
    // Header byte selection
    // ------------------------------------------------------------
    // Outer fields go most significant byte first.
    // Options go out exactly as set, several bits together.
    // Zero options is legal and lets the module pick defaults.
    logic [7:0] hbyte;
    always_comb begin
        hbyte = 8'h00;
        case (hidx_q)
            5'd0: hbyte = `RTRF_START;
            5'd1: hbyte = frame_len[15:8];
            5'd2: hbyte = frame_len[7:0];
            5'd3: hbyte = explicit_q ? `RTRF_TYPE_EXPL : `RTRF_TYPE_TX;
            5'd4: hbyte = frame_id_q;
            5'd5: hbyte = dest64_q[63:56];
            5'd6: hbyte = dest64_q[55:48];
            5'd7: hbyte = dest64_q[47:40];
            5'd8: hbyte = dest64_q[39:32];
            5'd9: hbyte = dest64_q[31:24];
            5'd10: hbyte = dest64_q[23:16];
            5'd11: hbyte = dest64_q[15:8];
            5'd12: hbyte = dest64_q[7:0];
            5'd13: hbyte = dest16_q[15:8];
            5'd14: hbyte = dest16_q[7:0];
            5'd15: hbyte = explicit_q ? src_ep_q : radius_q;
            5'd16: hbyte = explicit_q ? dst_ep_q : opts_q;
            5'd17: hbyte = cluster_q[15:8];
            5'd18: hbyte = cluster_q[7:0];
            5'd19: hbyte = profile_q[15:8];
            5'd20: hbyte = profile_q[7:0];
            5'd21: hbyte = radius_q;
            5'd22: hbyte = opts_q;
            default: hbyte = 8'h00;
        endcase
    end

    // The checksum skips start and length bytes.
    wire counted = hidx_q > 5'd2;
    wire [7:0] cks = `RTRF_CKS_BASE - sum_q;
    wire take = !tx_valid_q || tx_ready;

    wire resp_done;
    wire [7:0] r_type;
    wire [7:0] r_id;
    wire [7:0] r_stat;
    wire [15:0] r_addr;
    wire r_ok;
    // A status matches only when its ID equals the one we sent.
    wire resp_hit = resp_done && r_ok && r_id == frame_id_q &&
        (r_type == `RTRF_TYPE_STAT || r_type == `RTRF_TYPE_XSTAT);

    rtrf_resp_parser u_parser (
        .pclk(pclk),
        .presetn(presetn),
        .rx_valid(rx_valid),
        .rx_byte(rx_byte),
        .done(resp_done),
        .frame_type(r_type),
        .frame_id(r_id),
        .status(r_stat),
        .short_addr(r_addr),
        .cks_ok(r_ok)
    );

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    // Writes handled here are dropped while busy_q is set; STAT clears and the CTRL bit 3 abort still act.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dest64_q <= `RTRF_ADDR_BCAST;
            dest16_q <= `RTRF_SHORT_UNK;
            frame_id_q <= 8'h00;
            radius_q <= 8'h00;
            opts_q <= 8'h00;
            src_ep_q <= `RTRF_EP_DATA;
            dst_ep_q <= `RTRF_EP_DATA;
            cluster_q <= `RTRF_CL_DATA;
            profile_q <= `RTRF_PROFILE_RST;
            maxpl_q <= `RTRF_MAXPL_RST;
            explicit_q <= 1'b0;
            pl_cnt_q <= 8'h00;
        end else if (wr && !busy_q) begin
            case (paddr)
                `RTRF_REG_CTRL: begin
                    explicit_q <= pwdata[1];
                    if (pwdata[2]) begin
                        pl_cnt_q <= 8'h00;
                    end
                end
                `RTRF_REG_ADDRH: dest64_q[63:32] <= pwdata;
                `RTRF_REG_ADDRL: dest64_q[31:0] <= pwdata;
                `RTRF_REG_FIELDS: begin
                    frame_id_q <= pwdata[7:0];
                    radius_q <= pwdata[15:8];
                    opts_q <= pwdata[23:16];
                    dest16_q[7:0] <= pwdata[31:24];
                end
                `RTRF_REG_APP: begin
                    src_ep_q <= pwdata[7:0];
                    dst_ep_q <= pwdata[15:8];
                    cluster_q <= pwdata[31:16];
                end
                `RTRF_REG_MAXPL: begin
                    maxpl_q <= pwdata[7:0];
                    dest16_q[15:8] <= pwdata[15:8];
                    profile_q <= pwdata[31:16];
                end
                `RTRF_REG_DATA: begin
                    // Payload bytes are stored in the order written.
                    if (pl_cnt_q != 8'hFF) begin
                        pl_cnt_q <= pl_cnt_q + 8'h01;
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk) begin
        if (wr_data && !busy_q) begin
            pl_mem[pl_cnt_q] <= pwdata[7:0];
        end
    end

    // ------------------------------------------------------------
    // Frame sender
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= rtrf_pkg::RTRF_IDLE;
            hidx_q <= 5'd0;
            pidx_q <= 8'h00;
            sum_q <= 8'h00;
            tx_byte_q <= 8'h00;
            tx_valid_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            if (tx_valid_q && tx_ready) begin
                tx_valid_q <= 1'b0;
            end
            case (st_q)
                rtrf_pkg::RTRF_IDLE: begin
                    if (go_ok) begin
                        busy_q <= 1'b1;
                        hidx_q <= 5'd0;
                        pidx_q <= 8'h00;
                        sum_q <= 8'h00;
                        st_q <= rtrf_pkg::RTRF_HDR;
                    end
                end
                rtrf_pkg::RTRF_HDR: begin
                    if (take) begin
                        tx_byte_q <= hbyte;
                        tx_valid_q <= 1'b1;
                        if (counted) begin
                            sum_q <= sum_q + hbyte;
                        end
                        hidx_q <= hidx_q + 5'd1;
                        if (hidx_q == hdr_end - 5'd1) begin
                            st_q <= pl_cnt_q == 8'h00 ?
                                rtrf_pkg::RTRF_CKS : rtrf_pkg::RTRF_PAY;
                        end
                    end
                end
                rtrf_pkg::RTRF_PAY: begin
                    if (take) begin
                        tx_byte_q <= pl_mem[pidx_q];
                        tx_valid_q <= 1'b1;
                        sum_q <= sum_q + pl_mem[pidx_q];
                        pidx_q <= pidx_q + 8'h01;
                        if (pidx_q + 8'h01 == pl_cnt_q) begin
                            st_q <= rtrf_pkg::RTRF_CKS;
                        end
                    end
                end
                rtrf_pkg::RTRF_CKS: begin
                    if (take) begin
                        tx_byte_q <= cks;
                        tx_valid_q <= 1'b1;
                        // With ID zero no answer comes, so do not wait.
                        st_q <= frame_id_q == 8'h00 ?
                            rtrf_pkg::RTRF_IDLE : rtrf_pkg::RTRF_WAIT;
                        busy_q <= frame_id_q != 8'h00;
                    end
                end
                rtrf_pkg::RTRF_WAIT: begin
                    // Software may abort with CTRL bit 3 if no answer comes.
                    if (resp_hit || (wr_ctrl && pwdata[3])) begin
                        busy_q <= 1'b0;
                        st_q <= rtrf_pkg::RTRF_IDLE;
                    end
                end
                default: st_q <= rtrf_pkg::RTRF_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Status flags and APB answer
    // ------------------------------------------------------------
    // A new response wins over a software clear in the same cycle.
    wire stat_clr = wr && paddr == `RTRF_REG_STAT;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_q <= 1'b0;
            resp_q <= 1'b0;
            resp_word_q <= 32'h0000_0000;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            if (go && (opt_bad || len_bad)) begin
                err_q <= 1'b1;
            end else if (stat_clr && pwdata[1]) begin
                err_q <= 1'b0;
            end
            if (resp_hit) begin
                resp_q <= 1'b1;
                resp_word_q <= {r_addr, r_stat, r_type};
            end else if (stat_clr && pwdata[2]) begin
                resp_q <= 1'b0;
            end
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            case (paddr)
                `RTRF_REG_CTRL: prdata <= {31'h0000_0000, explicit_q} << 1;
                `RTRF_REG_STAT: prdata <= {24'h00_0000, pl_cnt_q[4:0],
                    resp_q, err_q, busy_q};
                `RTRF_REG_ADDRH: prdata <= dest64_q[63:32];
                `RTRF_REG_ADDRL: prdata <= dest64_q[31:0];
                `RTRF_REG_FIELDS: prdata <= {dest16_q[7:0], opts_q, radius_q,
                    frame_id_q};
                `RTRF_REG_APP: prdata <= {cluster_q, dst_ep_q, src_ep_q};
                `RTRF_REG_MAXPL: prdata <= {profile_q, dest16_q[15:8], maxpl_q};
                `RTRF_REG_RESP: prdata <= resp_word_q;
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    assign tx_byte = tx_byte_q;
    assign tx_valid = tx_valid_q;

    // Reserved option bits never leave the host on the options byte.
    a_opt_clean: assert property (@(posedge pclk) disable iff (!presetn)
        st_q == rtrf_pkg::RTRF_HDR && take && hidx_q == hdr_end - 5'd1 |=>
        (tx_byte_q & ~`RTRF_OPT_MASK) == 8'h00)
        else $error("reserved option bit sent");
    // Start delimiter is the first byte of each frame.
    a_start_byte: assert property (@(posedge pclk) disable iff (!presetn)
        st_q == rtrf_pkg::RTRF_IDLE && go_ok ##1 take [*1] |=>
        tx_byte_q == `RTRF_START)
        else $error("frame does not open with start byte");
    // Zero frame ID returns to idle right after the checksum.
    a_no_wait_id0: assert property (@(posedge pclk) disable iff (!presetn)
        st_q == rtrf_pkg::RTRF_CKS && take && frame_id_q == 8'h00 |=>
        st_q == rtrf_pkg::RTRF_IDLE && !busy_q)
        else $error("waiting for a suppressed response");
    // Payload stays within the shrunken limit for the whole frame.
    a_len_limit: assert property (@(posedge pclk) disable iff (!presetn)
        busy_q && st_q != rtrf_pkg::RTRF_IDLE |-> pl_cnt_q <= limit)
        else $error("payload over maximum");
    // Byte held stable while the module stalls.
    a_tx_hold: assert property (@(posedge pclk) disable iff (!presetn)
        tx_valid_q && !tx_ready |=> tx_valid_q && $stable(tx_byte_q))
        else $error("byte changed under stall");
    // Matching response releases the busy state next cycle.
    a_resp_free: assert property (@(posedge pclk) disable iff (!presetn)
        st_q == rtrf_pkg::RTRF_WAIT && resp_hit |=> !busy_q && resp_q)
        else $error("response did not end wait");
    // Type byte matches the selected frame kind.
    a_type_byte: assert property (@(posedge pclk) disable iff (!presetn)
        st_q == rtrf_pkg::RTRF_HDR && take && hidx_q == 5'd3 |=>
        tx_byte_q == (explicit_q ? `RTRF_TYPE_EXPL : `RTRF_TYPE_TX))
        else $error("wrong frame type byte");
    // Checksum plus sum gives 0xFF.
    a_cks_sum: assert property (@(posedge pclk) disable iff (!presetn)
        st_q == rtrf_pkg::RTRF_CKS && take |=>
        tx_byte_q + $past(sum_q) == `RTRF_CKS_BASE)
        else $error("bad checksum byte");
endmodule : rtrf_host

// File: rtl/rtrf_params.svh
// Constants for the transmit request framer host controller.
`ifndef RTRF_PARAMS_SVH
`define RTRF_PARAMS_SVH
`define RTRF_START 8'h7E
`define RTRF_TYPE_TX 8'h10
`define RTRF_TYPE_EXPL 8'h11
`define RTRF_TYPE_STAT 8'h89
`define RTRF_TYPE_XSTAT 8'h8B
`define RTRF_CKS_BASE 8'hFF
`define RTRF_OPT_MASK 8'h7D
`define RTRF_OPT_SECURE 8'h10
`define RTRF_OPT_LINKKEY 8'h20
`define RTRF_ENC_OVERHEAD 8'h04
`define RTRF_ADDR_BCAST 64'h0000_0000_0000_FFFF
`define RTRF_ADDR_SHORT 64'hFFFF_FFFF_FFFF_FFFF
`define RTRF_ADDR_COORD 64'h0000_0000_0000_0000
`define RTRF_SHORT_UNK 16'hFFFE
`define RTRF_SHORT_COORD 16'h0000
`define RTRF_EP_DATA 8'hE8
`define RTRF_CL_DATA 16'h0011
`define RTRF_HDR_TX 8'h0E
`define RTRF_HDR_EXPL 8'h14
`define RTRF_HDR_TX_END 5'h11
`define RTRF_HDR_EXPL_END 5'h17
`define RTRF_REG_CTRL 12'h000
`define RTRF_REG_STAT 12'h004
`define RTRF_REG_ADDRH 12'h008
`define RTRF_REG_ADDRL 12'h00C
`define RTRF_REG_FIELDS 12'h010
`define RTRF_REG_APP 12'h014
`define RTRF_REG_MAXPL 12'h018
`define RTRF_REG_DATA 12'h01C
`define RTRF_REG_RESP 12'h020
`define RTRF_PL_DEPTH 256
`define RTRF_MAXPL_RST 8'h54
`define RTRF_PROFILE_RST 16'hC105
`endif

// File: rtl/rtrf_pkg.sv
// Types shared by the transmit request framer host controller.
package rtrf_pkg;
    typedef enum logic [2:0] {
        RTRF_IDLE = 3'b000,
        RTRF_HDR = 3'b001,
        RTRF_PAY = 3'b010,
        RTRF_CKS = 3'b011,
        RTRF_WAIT = 3'b100
    } rtrf_state_t;
    typedef enum logic [2:0] {
        RTRF_RX_START = 3'b000,
        RTRF_RX_LENH = 3'b001,
        RTRF_RX_LENL = 3'b010,
        RTRF_RX_BODY = 3'b011,
        RTRF_RX_CKS = 3'b100
    } rtrf_rx_state_t;
endpackage : rtrf_pkg

// File: rtl/rtrf_resp_parser.sv
// Parser for status frames coming back from the radio module.
`include "rtrf_params.svh"
module rtrf_resp_parser (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic rx_valid,
    input wire logic [7:0] rx_byte,
    output logic done,
    output logic [7:0] frame_type,
    output logic [7:0] frame_id,
    output logic [7:0] status,
    output logic [15:0] short_addr,
    output logic cks_ok
);
    rtrf_pkg::rtrf_rx_state_t st_q;
    logic [15:0] len_q;
    logic [15:0] idx_q;
    logic [7:0] sum_q;
    logic [7:0] last_q;
    logic [7:0] b1_q;
    logic [7:0] b2_q;

    // Byte sum plus the checksum must equal 0xFF for a clean frame.
    wire [7:0] sum_with_cks = sum_q + rx_byte;
    wire body_last = (idx_q + 16'h0001) == len_q;

    // ------------------------------------------------------------
    // Frame walker
    // ------------------------------------------------------------
    // Field positions follow the type: 0x8B carries short address.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= rtrf_pkg::RTRF_RX_START;
            len_q <= 16'h0000;
            idx_q <= 16'h0000;
            sum_q <= 8'h00;
            last_q <= 8'h00;
            b1_q <= 8'h00;
            b2_q <= 8'h00;
            done <= 1'b0;
            frame_type <= 8'h00;
            frame_id <= 8'h00;
            status <= 8'h00;
            short_addr <= 16'h0000;
            cks_ok <= 1'b0;
        end else begin
            done <= 1'b0;
            if (rx_valid) begin
                case (st_q)
                    rtrf_pkg::RTRF_RX_START: begin
                        if (rx_byte == `RTRF_START) begin
                            st_q <= rtrf_pkg::RTRF_RX_LENH;
                        end
                    end
                    rtrf_pkg::RTRF_RX_LENH: begin
                        len_q[15:8] <= rx_byte;
                        st_q <= rtrf_pkg::RTRF_RX_LENL;
                    end
                    rtrf_pkg::RTRF_RX_LENL: begin
                        len_q[7:0] <= rx_byte;
                        idx_q <= 16'h0000;
                        sum_q <= 8'h00;
                        st_q <= rtrf_pkg::RTRF_RX_BODY;
                    end
                    rtrf_pkg::RTRF_RX_BODY: begin
                        sum_q <= sum_with_cks;
                        idx_q <= idx_q + 16'h0001;
                        case (idx_q)
                            16'h0000: frame_type <= rx_byte;
                            16'h0001: frame_id <= rx_byte;
                            16'h0002: b1_q <= rx_byte;
                            16'h0003: b2_q <= rx_byte;
                            default: last_q <= rx_byte;
                        endcase
                        if (body_last) begin
                            st_q <= rtrf_pkg::RTRF_RX_CKS;
                        end
                    end
                    rtrf_pkg::RTRF_RX_CKS: begin
                        done <= 1'b1;
                        cks_ok <= sum_with_cks == `RTRF_CKS_BASE;
                        if (frame_type == `RTRF_TYPE_XSTAT) begin
                            short_addr <= {b1_q, b2_q};
                            status <= last_q;
                        end else begin
                            short_addr <= `RTRF_SHORT_UNK;
                            status <= b1_q;
                        end
                        st_q <= rtrf_pkg::RTRF_RX_START;
                    end
                    default: st_q <= rtrf_pkg::RTRF_RX_START;
                endcase
            end
        end
    end
endmodule : rtrf_resp_parser

// File: test/rtrf_host_bench.sv
// Self-checking bench for the transmit request host controller.
`include "rtrf_params.svh"
module rtrf_host_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
    logic pwrite = 1'h0, sl, pready, pslverr, tx_valid, tx_ready, rx_valid;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [7:0] tx_byte, rx_byte;
    logic [63:0] bad [2] = '{64'hFE020033_C105FF54, 64'hFE100033_C105FF04};
    int error_cnt = 0, checked = 0, k, j;
    rtrf_host i_rtrf_host (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .rx_valid(rx_valid), .rx_byte(rx_byte));
    rtrf_radio_model i_rtrf_radio_model (.pclk(pclk), .presetn(presetn),
        .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .rx_valid(rx_valid), .rx_byte(rx_byte));
    // ----------------------------------------------------------
    // Clock, tasks and comparison
    // ----------------------------------------------------------
    initial begin
        forever #10 pclk = ~pclk;
    end
    task conclude;
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude
    task chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checked++;
        if (s !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // Pready is sampled at the rising edge that completes the access.
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'h1 && k < 50);
        if (k >= 50) begin
            error_cnt++;
            conclude();
        end
        rd = prdata;
        sl = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb
    task idle;
        j = 0;
        do begin
            apb(1'h0, `RTRF_REG_STAT, 32'h0);
            j++;
        end while (rd[0] !== 1'h0 && j < 100);
        if (j >= 100) begin
            error_cnt++;
            conclude();
        end
    endtask : idle
    // Expected frame is rebuilt from the body bytes alone.
    task frame(input logic [167:0] v, input int nb);
        logic [7:0] b [$];
        logic [7:0] s;
        // Busy may drop before the checksum byte has crossed the link.
        repeat (4) @(posedge pclk);
        s = 8'hFF;
        b = {8'h7E, 8'h00, 8'(nb)};
        for (int i = nb - 1; i >= 0; i--) begin
            b.push_back(v[8*i +: 8]);
            s -= v[8*i +: 8];
        end
        b.push_back(s);
        chk("frame size", b.size(), i_rtrf_radio_model.last_n);
        foreach (b[i]) begin
            chk("frame byte", b[i], i_rtrf_radio_model.fr[i]);
        end
    endtask : frame
    // ----------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'h1;
        apb(1'h0, `RTRF_REG_APP, 32'h0);
        chk("app reset", 32'h0011E8E8, rd);
        apb(1'h1, `RTRF_REG_ADDRH, 32'h11223344);
        apb(1'h1, `RTRF_REG_ADDRL, 32'h55667788);
        apb(1'h1, `RTRF_REG_FIELDS, 32'hFE010052);
        apb(1'h1, `RTRF_REG_DATA, 32'h54);
        apb(1'h1, `RTRF_REG_DATA, 32'h78);
        apb(1'h1, `RTRF_REG_CTRL, 32'h1);
        idle();
        frame(168'h10_52_11223344_55667788_FFFE_0001_5478, 16);
        apb(1'h0, `RTRF_REG_RESP, 32'h0);
        chk("plain status", 32'h89, {16'h0, rd[15:0]});
        i_rtrf_radio_model.slow = 1'h1;
        apb(1'h1, `RTRF_REG_CTRL, 32'h4);
        apb(1'h1, `RTRF_REG_DATA, 32'h41);
        apb(1'h1, `RTRF_REG_FIELDS, 32'hFE210087);
        apb(1'h1, `RTRF_REG_CTRL, 32'h3);
        idle();
        frame(168'h11871122334455667788FFFEE8E80011C105002141, 21);
        apb(1'h0, `RTRF_REG_RESP, 32'h0);
        chk("explicit status", 32'h1234008B, rd);
        foreach (bad[i]) begin
            apb(1'h1, `RTRF_REG_MAXPL, bad[i][31:0]);
            apb(1'h1, `RTRF_REG_FIELDS, bad[i][63:32]);
            apb(1'h1, `RTRF_REG_CTRL, 32'h1);
            apb(1'h0, `RTRF_REG_STAT, 32'h0);
            chk("refused go", 32'h2, {30'h0, rd[1:0]});
            apb(1'h1, `RTRF_REG_STAT, 32'h2);
        end
        apb(1'h1, `RTRF_REG_MAXPL, 32'hC105FF54);
        apb(1'h1, `RTRF_REG_ADDRH, 32'h0);
        apb(1'h1, `RTRF_REG_ADDRL, 32'hFFFF);
        apb(1'h1, `RTRF_REG_FIELDS, 32'hFE000000);
        apb(1'h1, `RTRF_REG_CTRL, 32'h1);
        idle();
        frame(168'h10_00_00000000_0000FFFF_FFFE_0000_41, 15);
        apb(1'h0, `RTRF_REG_RESP, 32'h0);
        chk("no reply", 32'h1234008B, rd);
        apb(1'h1, `RTRF_REG_ADDRH, 32'hFFFFFFFF);
        apb(1'h1, `RTRF_REG_ADDRL, 32'hFFFFFFFF);
        apb(1'h1, `RTRF_REG_MAXPL, 32'hC1051254);
        apb(1'h1, `RTRF_REG_FIELDS, 32'h34000000);
        apb(1'h1, `RTRF_REG_CTRL, 32'h1);
        idle();
        frame(168'h10_00_FFFFFFFF_FFFFFFFF_1234_0000_41, 15);
        apb(1'h1, `RTRF_REG_ADDRH, 32'h0);
        apb(1'h1, `RTRF_REG_ADDRL, 32'h0);
        apb(1'h1, `RTRF_REG_MAXPL, 32'hC105FF54);
        apb(1'h1, `RTRF_REG_FIELDS, 32'hFE000000);
        apb(1'h1, `RTRF_REG_CTRL, 32'h1);
        idle();
        frame(168'h10_00_00000000_00000000_FFFE_0000_41, 15);
        apb(1'h0, 12'h0FC, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, sl});
        conclude();
    end
endmodule : rtrf_host_bench

// File: test/rtrf_radio_model.sv
// Behavioural radio module on the far side of the request byte link.
module rtrf_radio_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] tx_byte,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic rx_valid,
    output logic [7:0] rx_byte
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] fr [0:63];
    logic [7:0] rsp [$];
    logic [7:0] sum;
    logic slow = 1'h0;
    int n, last_n;
    // ----------------------------------------------------------
    // Frame capture and status reply
    // ----------------------------------------------------------
    // A bad frame gets no reply, so a careless host stays busy.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            n = 0;
            rsp.delete();
            tx_ready <= 1'h0;
            rx_valid <= 1'h0;
            rx_byte <= 8'h00;
        end else begin
            tx_ready <= slow ? ~tx_ready : 1'h1;
            if (tx_valid && tx_ready && n < 64) begin
                fr[n] = tx_byte;
                n++;
            end
            if (n > 3 && n == {fr[1], fr[2]} + 4) begin
                sum = 8'h00;
                for (int i = 3; i < n; i++) begin
                    sum += fr[i];
                end
                if (sum != 8'hFF || fr[4] == 8'h00) begin
                    rsp = {};
                end else if (fr[3] == 8'h10) begin
                    rsp = {8'h7E, 8'h00, 8'h03, 8'h89, fr[4], 8'h00,
                        8'h76 - fr[4]};
                end else begin
                    rsp = {8'h7E, 8'h00, 8'h07, 8'h8B, fr[4], 8'h12,
                        8'h34, 8'h00, 8'h00, 8'h00, 8'h2E - fr[4]};
                end
                last_n = n;
                n = 0;
            end
            // Idle bytes keep changing so a stale value is never trusted.
            rx_valid <= rsp.size() > 0;
            rx_byte <= rsp.size() > 0 ? rsp.pop_front() : ~rx_byte;
        end
    end
endmodule : rtrf_radio_model
